// >>> verilog/iepb_bank.sv
// Purpose: interrupt enable and priority bank with per-source request forwarding
// Assumes: sources pulse or hold request lines synchronous to clk
// Notes: word 0 flags are sticky until software writes zero to them; flags of words 1-4 never clear
//
// Overview of operation
// - an enable bit of one passes its source request, zero blocks it
// - unimplemented bits read zero and ignore writes
// - implemented enable bits are read/write and reset to zero
// - priority fields are three bits; code 111 means level 7, highest
// - code 001 is level 1, lowest; middle codes map to matching levels
// - priority code 000 disables the source regardless of enable; here it is never forwarded but still raises status event 0 when enabled
// - every priority field resets to 100, level 4
// - priority word 0: timer1 14-12, compare1 10-8, capture1 6-4, extirq0 2-0
// - enable word 1 source layout, bit 15 down to bit 0, bit 5 unused
// - enable word 2: dma4, parallel port, dma3, can event/rx, spi2 event/error
// - without the CAN controller its three sources stay disabled; here they never forward but still raise status event 0 when enabled
// - without the audio DAC its two sources stay disabled; here they never forward but still raise status event 0 when enabled
// - enable word 3: pwm1 fault, rtc, dma5, encoder1, pwm1 error
// - enable word 4: dac, encoder2, pwm2, can tx, dma7/6, crc, uart errors
// - enable word 0 low bits: compare1, capture1, extirq0
// - a flag reads one once its source has requested, zero otherwise; here only the word 0 flags can be read, at the flag word
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "iepb_map.svh"
module iepb_bank #(
   parameter bit HAS_CAN = 1'b1,
   parameter bit HAS_DAC = 1'b1
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                reset,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // peripheral request lines, same layout as the enable words
   input  wire iepb_pkg::iepb_word_t [4:0] srcReq,
   // requests forwarded to core arbitration, with priority levels of word 0 sources
   output iepb_pkg::iepb_word_t [4:0] fwdReq,
   output logic [11:0]              prio0Levels,
   // bank interrupt
   output logic                     irq
);
   iepb_pkg::iepb_state_t st_reg;
   iepb_pkg::iepb_state_t st_next;
   iepb_pkg::iepb_word_t  implMask [5];
   iepb_pkg::iepb_word_t  varMask  [5];
   iepb_pkg::iepb_word_t  reqMasked[5];
   logic [3:0]            events;
   logic                  wr;
   logic                  rd;

   // masks of implemented enable positions per word
   assign implMask[0] = `IEPB_MASK_ENABLE0;
   assign implMask[1] = `IEPB_MASK_ENABLE1;
   assign implMask[2] = `IEPB_MASK_ENABLE2;
   assign implMask[3] = `IEPB_MASK_ENABLE3;
   assign implMask[4] = `IEPB_MASK_ENABLE4;
   // variants lacking a peripheral block forwarding of its sources, even if enabled
   assign varMask[0] = 16'hFFFF;
   assign varMask[1] = 16'hFFFF;
   assign varMask[2] = HAS_CAN ? 16'hFFFF : ~`IEPB_CAN_ENABLE2;
   assign varMask[3] = 16'hFFFF;
   assign varMask[4] = (HAS_CAN ? 16'hFFFF : ~`IEPB_CAN_ENABLE4)
                     & (HAS_DAC ? 16'hFFFF : ~`IEPB_DAC_ENABLE4);

   // word 0 sources carry priority: compare1 bit 2, capture1 bit 1, extirq0 bit 0
   always_comb
   begin
      for (int w = 0; w < 5; w++)
      begin
         reqMasked[w] = st_reg.flag[w] & st_reg.enable[w] & varMask[w];
      end
      // code 000 disables regardless of enable bit
      reqMasked[0][2] = reqMasked[0][2] & (st_reg.prio[10:8] != 3'h0);
      reqMasked[0][1] = reqMasked[0][1] & (st_reg.prio[6:4] != 3'h0);
      reqMasked[0][0] = reqMasked[0][0] & (st_reg.prio[2:0] != 3'h0);
   end

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   always_comb
   begin
      st_next = st_reg;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      events = 4'h0;
      for (int w = 0; w < 5; w++)
      begin
         // an enabled request on a clear flag raises status event 0; flags are set below
         if (|(srcReq[w] & implMask[w] & ~st_reg.flag[w] & st_reg.enable[w]))
         begin
            events[0] = 1'b1;
         end
      end
      // software write of flags clears, but set wins over clear
      if (wr && !st_reg.pready)
      begin
         if (paddr == `IEPB_OFS_ENABLE0)
         begin
            st_next.enable[0] = pwdata[15:0] & implMask[0];
         end
         else if (paddr == `IEPB_OFS_ENABLE1)
         begin
            st_next.enable[1] = pwdata[15:0] & implMask[1];
         end
         else if (paddr == `IEPB_OFS_ENABLE2)
         begin
            st_next.enable[2] = pwdata[15:0] & implMask[2];
         end
         else if (paddr == `IEPB_OFS_ENABLE3)
         begin
            st_next.enable[3] = pwdata[15:0] & implMask[3];
         end
         else if (paddr == `IEPB_OFS_ENABLE4)
         begin
            st_next.enable[4] = pwdata[15:0] & implMask[4];
         end
         else if (paddr == `IEPB_OFS_PRIO0)
         begin
            st_next.prio = pwdata[15:0] & `IEPB_MASK_PRIO0;
         end
         else if (paddr == `IEPB_OFS_FLAGS)
         begin
            // writes to the flag word clear bits written as zero
            st_next.flag[0] = st_reg.flag[0] & pwdata[15:0];
         end
         else if (paddr == `IEPB_OFS_IRQ_MASK)
         begin
            st_next.mask = pwdata[3:0];
         end
         else
         begin
            st_next.pslverr = 1'b1;
         end
         st_next.pready = 1'b1;
      end
      else if (rd && !st_reg.pready)
      begin
         if (paddr == `IEPB_OFS_ENABLE0)
         begin
            st_next.prdata = {16'h0000, st_reg.enable[0]};
         end
         else if (paddr == `IEPB_OFS_ENABLE1)
         begin
            st_next.prdata = {16'h0000, st_reg.enable[1]};
         end
         else if (paddr == `IEPB_OFS_ENABLE2)
         begin
            st_next.prdata = {16'h0000, st_reg.enable[2]};
         end
         else if (paddr == `IEPB_OFS_ENABLE3)
         begin
            st_next.prdata = {16'h0000, st_reg.enable[3]};
         end
         else if (paddr == `IEPB_OFS_ENABLE4)
         begin
            st_next.prdata = {16'h0000, st_reg.enable[4]};
         end
         else if (paddr == `IEPB_OFS_PRIO0)
         begin
            st_next.prdata = {16'h0000, st_reg.prio};
         end
         else if (paddr == `IEPB_OFS_FLAGS)
         begin
            st_next.prdata = {16'h0000, st_reg.flag[0]};
         end
         else if (paddr == `IEPB_OFS_IRQ_STAT)
         begin
            st_next.prdata = {28'h000_0000, st_reg.stat};
            st_next.stat = 4'h0;
         end
         else if (paddr == `IEPB_OFS_IRQ_MASK)
         begin
            st_next.prdata = {28'h000_0000, st_reg.mask};
         end
         else
         begin
            st_next.pslverr = 1'b1;
         end
         st_next.pready = 1'b1;
      end
      // flags follow requests; set wins over any clear in the same cycle
      for (int w = 0; w < 5; w++)
      begin
         st_next.flag[w] = (st_next.flag[w] | srcReq[w]) & implMask[w];
         st_next.fwd[w] = reqMasked[w];
      end
      events[1] = |(reqMasked[0] | reqMasked[1] | reqMasked[2]);
      events[2] = |(reqMasked[3] | reqMasked[4]);
      events[3] = st_next.pslverr;
      // sticky status; event wins over read-clear
      st_next.stat = st_next.stat | events;
      st_next.irq = |(st_next.stat & st_next.mask);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_reg <= '0;
         st_reg.prio <= `IEPB_RESET_PRIO0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign pready = st_reg.pready;
   assign prdata = st_reg.prdata;
   assign pslverr = st_reg.pslverr;
   assign fwdReq = st_reg.fwd;
   // levels: timer1, compare1, capture1, extirq0; code equals level 1..7
   assign prio0Levels = {st_reg.prio[14:12], st_reg.prio[10:8],
                         st_reg.prio[6:4], st_reg.prio[2:0]};
   assign irq = st_reg.irq;
endmodule : iepb_bank

// >>> verilog/iepb_map.svh
// Purpose: register offsets, field positions, reset values for the enable/priority bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: offsets are local to this bank
`ifndef IEPB_MAP_SVH
`define IEPB_MAP_SVH
`define IEPB_OFS_ENABLE0    12'h000
`define IEPB_OFS_ENABLE1    12'h004
`define IEPB_OFS_ENABLE2    12'h008
`define IEPB_OFS_ENABLE3    12'h00C
`define IEPB_OFS_ENABLE4    12'h010
`define IEPB_OFS_PRIO0      12'h014
`define IEPB_OFS_FLAGS      12'h018
`define IEPB_OFS_IRQ_STAT   12'h01C
`define IEPB_OFS_IRQ_MASK   12'h020
`define IEPB_MASK_ENABLE0   16'h0007
`define IEPB_MASK_ENABLE1   16'hFFDF
`define IEPB_MASK_ENABLE2   16'h601F
`define IEPB_MASK_ENABLE3   16'hE600
`define IEPB_MASK_ENABLE4   16'hCE7E
`define IEPB_MASK_PRIO0     16'h7777
`define IEPB_RESET_PRIO0    16'h4444
`define IEPB_CAN_ENABLE2    16'h000C
`define IEPB_CAN_ENABLE4    16'h0040
`define IEPB_DAC_ENABLE4    16'hC000
`define IEPB_NUM_PRIO       4
`define IEPB_PRIO_W         3
`endif

// >>> verilog/iepb_pkg.sv
// Purpose: types for the enable/priority bank
// Assumes: 16-bit control words
// Notes: none
package iepb_pkg;
   typedef logic [15:0] iepb_word_t;
   typedef logic [2:0]  iepb_prio_t;
   typedef struct packed {
      iepb_word_t [4:0] enable;
      iepb_word_t       prio;
      iepb_word_t [4:0] flag;
      iepb_word_t [4:0] fwd;
      logic       [3:0] stat;
      logic       [3:0] mask;
      logic             irq;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
   } iepb_state_t;
endpackage : iepb_pkg

// >>> sim/iepb_bank_chk.sv
// Purpose: port checker for iepb_bank
// Assumes: apb master holds a request until pready
// Notes: bound at the foot
`timescale 1ns/1ps
`include "iepb_map.svh"
module iepb_bank_chk (
   // clock and reset
   input wire logic                       clk,
   input wire logic                       reset,
   // apb
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [11:0]                paddr,
   input wire logic                       pready,
   input wire logic [31:0]                prdata,
   input wire logic                       pslverr,
   // core side
   input wire iepb_pkg::iepb_word_t [4:0] fwdReq,
   input wire logic [11:0]                prio0Levels,
   input wire logic                       irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_ready_time: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready late");
   a_bad_addr: assert property (pready && psel && paddr > 12'h020 |-> pslverr)
      else $error("no slave error");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper half set");
   a_prio_gaps: assert property (pready && !pwrite && paddr == `IEPB_OFS_PRIO0
      |-> (prdata[15:0] & 16'h8888) == 16'h0000) else $error("priority gap set");
   a_reset_prio: assert property ($fell(reset) |-> prio0Levels == 12'h924)
      else $error("priority reset");
   a_reset_quiet: assert property ($fell(reset) |-> fwdReq == '0 && !irq)
      else $error("forward after reset");
   a_prio_zero: assert property ((prio0Levels[2:0] == 3'b000) [*2] |-> !fwdReq[0][0])
      else $error("zero priority forwarded");
   a_gap_fwd: assert property ((fwdReq[3] & ~`IEPB_MASK_ENABLE3) == 16'h0000)
      else $error("gap forwarded");
   c_irq: cover property (irq);
   c_err: cover property (pready && pslverr);
   c_fwd: cover property (fwdReq[0] == 16'h0007);
endmodule : iepb_bank_chk
bind iepb_bank iepb_bank_chk u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .fwdReq(fwdReq), .prio0Levels(prio0Levels), .irq(irq));

// >>> sim/iepb_src_model.sv
// Purpose: peripheral event sources
// Assumes: one-cycle pulse per trigger
// Notes: pulses only, so the bank must hold the event
`timescale 1ns/1ps
module iepb_src_model (
   // clock
   input  wire logic                       clk,
   // stimulus
   input  wire logic                       trig,
   input  wire iepb_pkg::iepb_word_t [4:0] pat,
   // request lines
   output iepb_pkg::iepb_word_t [4:0]      srcReq
);
   initial srcReq = '0;
   always @(posedge clk)
   begin
      srcReq <= trig ? pat : '0;
   end
endmodule : iepb_src_model

// >>> sim/iepb_bank_tb_top.sv
// Purpose: self-checking bench for iepb_bank
// Assumes: default variant with both optional modules, plus a variant with neither
// Notes: flags of words 1-4 stay set, so gating shows per enable
`timescale 1ns/1ps
module iepb_bank_tb_top;
   logic                       clk, reset, psel, penable, pwrite, trig, pready, pslverr, irq, err;
   logic [11:0]                paddr, prio0Levels;
   logic [31:0]                pwdata, prdata, rd;
   iepb_pkg::iepb_word_t [4:0] pat, srcReq, fwdReq, expFwd, varFwd;
   int                         n_fail, num_checks;
   logic [15:0]                masks [5] = '{16'h0007, 16'hFFDF, 16'h601F, 16'hE600, 16'hCE7E};
   iepb_bank dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .srcReq(srcReq), .fwdReq(fwdReq), .prio0Levels(prio0Levels), .irq(irq));
   // variant without the optional controllers, fed the same bus and requests
   iepb_bank #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) dutVar (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(), .prdata(), .pslverr(), .srcReq(srcReq), .fwdReq(varFwd),
      .prio0Levels(), .irq());
   iepb_src_model src (.clk(clk), .trig(trig), .pat(pat), .srcReq(srcReq));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : chk
   // holds the request until pready is sampled high; bounded wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1 && ++i < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_fail++;
         complete_run();
      end
   endtask : apb
   task automatic chk_fwd(input string nm);
      int i = 0;
      while (fwdReq !== expFwd && i++ < 10)
         @(posedge clk);
      chk(nm, fwdReq, expFwd);
   endtask : chk_fwd
   task automatic chk_irq(input logic e);
      int i = 0;
      while (irq !== e && i++ < 10)
         @(posedge clk);
      chk("irq", irq, e);
   endtask : chk_irq
   initial
   begin
      {reset, psel, penable, pwrite, trig} = 5'b10000;
      {paddr, pwdata, pat, expFwd, n_fail, num_checks} = '0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int w = 0; w < 5; w++)
      begin
         apb(1'b0, 12'(w * 4), 32'h0);
         chk("enable reset", rd, 32'h0);
         apb(1'b1, 12'(w * 4), 32'hFFFFFFFF);
         apb(1'b0, 12'(w * 4), 32'h0);
         chk("enable bits", rd, masks[w]);
      end
      apb(1'b0, 12'h014, 32'h0);
      chk("prio reset", rd, 32'h4444);
      apb(1'b1, 12'h014, 32'hFFFFFFFF);
      apb(1'b0, 12'h014, 32'h0);
      chk("prio bits", rd, 32'h7777);
      chk("levels top", prio0Levels, 12'hFFF);
      apb(1'b0, 12'h018, 32'h0);
      chk("flags idle", rd, 32'h0);
      apb(1'b1, 12'h014, 32'h0);
      @(posedge clk);
      pat  <= {16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0007};
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      expFwd = {16'hCE7E, 16'hE600, 16'h601F, 16'hFFDF, 16'h0000};
      chk_fwd("fwd prio zero");
      chk("fwd variant", varFwd, {16'h0E3E, 16'hE600, 16'h6013, 16'hFFDF, 16'h0000});
      apb(1'b0, 12'h018, 32'h0);
      chk("flags set", rd, 32'h0007);
      apb(1'b1, 12'h014, 32'h0111);
      expFwd[0] = 16'h0007;
      chk_fwd("fwd prio one");
      chk("levels low", prio0Levels, 12'h049);
      apb(1'b1, 12'h004, 32'h0);
      expFwd[1] = 16'h0000;
      chk_fwd("fwd disabled");
      apb(1'b1, 12'h018, 32'h0);
      expFwd[0] = 16'h0000;
      chk_fwd("fwd no flag");
      apb(1'b0, 12'h01C, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk("bus error", err, 1'b1);
      chk_irq(1'b0);
      apb(1'b1, 12'h020, 32'h8);
      chk_irq(1'b1);
      apb(1'b0, 12'h01C, 32'h0);
      chk("status error", rd[3], 1'b1);
      chk_irq(1'b0);
      complete_run();
   end
endmodule : iepb_bank_tb_top
